// ### hw/bci_pkg.sv
// Purpose: Shared constants and types for the baseline core instruction subset
// Assumes: 12-bit instruction words, 9-bit program counter, 32 file registers
// Notes:   Opcode patterns are match/mask pairs on the fetched word
package bci_pkg;

    // ------------------------------------------------------------------
    // Widths, file depth and destination bit
    // ------------------------------------------------------------------
    localparam int BCI_INSTR_W     = 12;
    localparam int BCI_PC_W        = 9;
    localparam int BCI_DATA_W      = 8;
    localparam int BCI_FILE_ADDR_W = 5;
    localparam int BCI_FILE_DEPTH  = 32;
    localparam int BCI_DEST_BIT    = 5;

    // ------------------------------------------------------------------
    // Opcode patterns
    // ------------------------------------------------------------------
    localparam logic [11:0] BCI_OPC_IDLE       = 12'h000;
    localparam logic [11:0] BCI_OPC_OPTION     = 12'h002;
    localparam logic [11:0] BCI_MASK_STORE     = 12'hfe0;
    localparam logic [11:0] BCI_OPC_STORE      = 12'h020;
    localparam logic [11:0] BCI_MASK_FILE_D    = 12'hfc0;
    localparam logic [11:0] BCI_OPC_OR_FILE    = 12'h100;
    localparam logic [11:0] BCI_OPC_MOVE_FILE  = 12'h200;
    localparam logic [11:0] BCI_OPC_INC_SKIP   = 12'h3c0;
    localparam logic [11:0] BCI_MASK_LITERAL   = 12'hf00;
    localparam logic [11:0] BCI_OPC_RETURN_IMM = 12'h800;
    localparam logic [11:0] BCI_OPC_LOAD_IMM   = 12'hc00;
    localparam logic [11:0] BCI_OPC_OR_IMM     = 12'hd00;

    // ------------------------------------------------------------------
    // Reset values and step sizes
    // ------------------------------------------------------------------
    localparam logic [8:0]  BCI_PC_RESET     = 9'h000;
    localparam logic [7:0]  BCI_W_RESET      = 8'h00;
    localparam logic [7:0]  BCI_OPTION_RESET = 8'hff;
    localparam logic        BCI_ZERO_RESET   = 1'b0;
    localparam logic [8:0]  BCI_PC_STEP      = 9'h001;
    localparam logic [7:0]  BCI_INC_STEP     = 8'h01;

    // ------------------------------------------------------------------
    // Decoded operations
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        BCI_OP_IDLE       = 4'b0000,
        BCI_OP_OPTION     = 4'b0001,
        BCI_OP_STORE      = 4'b0010,
        BCI_OP_OR_FILE    = 4'b0011,
        BCI_OP_MOVE_FILE  = 4'b0100,
        BCI_OP_INC_SKIP   = 4'b0101,
        BCI_OP_RETURN_IMM = 4'b0110,
        BCI_OP_LOAD_IMM   = 4'b0111,
        BCI_OP_OR_IMM     = 4'b1000,
        BCI_OP_UNKNOWN    = 4'b1001
    } bci_op_type;

endpackage : bci_pkg

// ### hw/bci_core.sv
// Purpose: Fetch/execute core for a subset of a baseline 8-bit instruction set
// Assumes: Program memory answers pm_addr combinationally in the same cycle
// Notes:   One instruction executes per cycle; a flush replaces the next with idle
//
// Notes on behaviour
// - increment_skip_zero_op adds one to the file register into W (d=0) or the file (d=1), flags untouched.
// - When the increment result is zero the already fetched instruction is discarded and an idle runs instead.
// - or_immediate_op ORs W with the 8-bit literal into W and sets the zero flag from the result.
// - or_file_op ORs W with the file register into W (d=0) or the file (d=1) and sets the zero flag.
// - store_working_op copies W into the addressed file register and leaves the flags alone.
// - move_file_op copies the file register to W (d=0) or back to itself (d=1).
// - move_file_op sets the zero flag from the moved value in both destinations, so it works as a zero test.
// - load_immediate_op puts the 8-bit literal into W and leaves the flags alone.
// - The option load copies W into the option register and leaves the flags alone.
// - return_immediate_op loads the literal into W, reloads the PC from return_stack_top and takes two cycles.
`timescale 1ns/1ps
`default_nettype none

module bci_core
    import bci_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // Program memory fetch
    output logic [8:0]       pm_addr,
    input  wire logic [11:0] pm_data,
    // Return stack
    input  wire logic [8:0]  return_stack_top,
    output logic             return_pop,
    // Core state
    output logic [7:0]       work_reg,
    output logic [7:0]       option_reg,
    output logic             zero_flag,
    output logic             unknown_op,
    // File register observation
    input  wire logic [4:0]  file_peek_addr,
    output logic [7:0]       file_peek_data
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [11:0]       instr;
    logic [7:0]        file_mem [BCI_FILE_DEPTH];
    bci_op_type        op;
    logic [4:0]        faddr;
    logic              dest_file;
    logic [7:0]        lit;
    logic [7:0]        fval;
    logic [7:0]        inc_val;
    logic [7:0]        or_file_val;
    logic [7:0]        or_imm_val;
    logic [7:0]        next_work;
    logic              next_zero;
    logic              file_we;
    logic [7:0]        file_wdata;
    logic              flush;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    assign faddr       = instr[BCI_FILE_ADDR_W-1:0];
    assign dest_file   = instr[BCI_DEST_BIT];
    assign lit         = instr[BCI_DATA_W-1:0];
    assign fval        = file_mem[faddr];
    assign inc_val     = fval + BCI_INC_STEP;
    assign or_file_val = work_reg | fval;
    assign or_imm_val  = work_reg | lit;

    always_comb begin
        if (instr == BCI_OPC_IDLE) begin
            op = BCI_OP_IDLE;
        end else if (instr == BCI_OPC_OPTION) begin
            op = BCI_OP_OPTION;
        end else if ((instr & BCI_MASK_STORE) == BCI_OPC_STORE) begin
            op = BCI_OP_STORE;
        end else if ((instr & BCI_MASK_FILE_D) == BCI_OPC_OR_FILE) begin
            op = BCI_OP_OR_FILE;
        end else if ((instr & BCI_MASK_FILE_D) == BCI_OPC_MOVE_FILE) begin
            op = BCI_OP_MOVE_FILE;
        end else if ((instr & BCI_MASK_FILE_D) == BCI_OPC_INC_SKIP) begin
            op = BCI_OP_INC_SKIP;
        end else if ((instr & BCI_MASK_LITERAL) == BCI_OPC_RETURN_IMM) begin
            op = BCI_OP_RETURN_IMM;
        end else if ((instr & BCI_MASK_LITERAL) == BCI_OPC_LOAD_IMM) begin
            op = BCI_OP_LOAD_IMM;
        end else if ((instr & BCI_MASK_LITERAL) == BCI_OPC_OR_IMM) begin
            op = BCI_OP_OR_IMM;
        end else begin
            op = BCI_OP_UNKNOWN;
        end
    end

    // ------------------------------------------------------------------
    // Execute
    // ------------------------------------------------------------------
    // Words outside the subset run as idle so the core never stalls on them
    always_comb begin
        next_work  = work_reg;
        next_zero  = zero_flag;
        file_we    = 1'b0;
        file_wdata = fval;
        flush      = 1'b0;
        unique case (op)
            BCI_OP_INC_SKIP: begin
                file_we    = dest_file;
                file_wdata = inc_val;
                if (!dest_file) begin
                    next_work = inc_val;
                end
                flush = (inc_val == 8'h00);
            end
            BCI_OP_OR_IMM: begin
                next_work = or_imm_val;
                next_zero = (or_imm_val == 8'h00);
            end
            BCI_OP_OR_FILE: begin
                file_we    = dest_file;
                file_wdata = or_file_val;
                if (!dest_file) begin
                    next_work = or_file_val;
                end
                next_zero = (or_file_val == 8'h00);
            end
            BCI_OP_STORE: begin
                file_we    = 1'b1;
                file_wdata = work_reg;
            end
            BCI_OP_MOVE_FILE: begin
                file_we    = dest_file;
                file_wdata = fval;
                if (!dest_file) begin
                    next_work = fval;
                end
                next_zero = (fval == 8'h00);
            end
            BCI_OP_LOAD_IMM: begin
                next_work = lit;
            end
            BCI_OP_RETURN_IMM: begin
                next_work = lit;
                flush     = 1'b1;
            end
            BCI_OP_OPTION, BCI_OP_IDLE, BCI_OP_UNKNOWN: begin
                next_work = work_reg;
            end
        endcase
    end

    assign return_pop = (op == BCI_OP_RETURN_IMM);
    assign unknown_op = (op == BCI_OP_UNKNOWN);

    // ------------------------------------------------------------------
    // Fetch and program counter
    // ------------------------------------------------------------------
    // A flushed slot becomes idle, which costs the second cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pm_addr <= BCI_PC_RESET;
            instr   <= BCI_OPC_IDLE;
        end else begin
            if (return_pop) begin
                pm_addr <= return_stack_top;
            end else begin
                pm_addr <= pm_addr + BCI_PC_STEP;
            end
            instr <= flush ? BCI_OPC_IDLE : pm_data;
        end
    end

    // ------------------------------------------------------------------
    // Working, option and zero registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            work_reg  <= BCI_W_RESET;
            zero_flag <= BCI_ZERO_RESET;
        end else begin
            work_reg  <= next_work;
            zero_flag <= next_zero;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            option_reg <= BCI_OPTION_RESET;
        end else if (op == BCI_OP_OPTION) begin
            option_reg <= work_reg;
        end
    end

    // ------------------------------------------------------------------
    // File registers
    // ------------------------------------------------------------------
    // Contents are left unreset, as a plain register file would be
    // A word caught in the slot as reset arrives must not write
    always_ff @(posedge sys_clk) begin
        if (rst_b && file_we) begin
            file_mem[faddr] <= file_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            file_peek_data <= 8'h00;
        end else begin
            file_peek_data <= file_mem[file_peek_addr];
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_inc_to_work;
        @(posedge sys_clk) disable iff (!rst_b)
        (op == BCI_OP_INC_SKIP && !dest_file) |=> (work_reg == $past(inc_val)) && $stable(zero_flag);
    endproperty
    a_inc_to_work: assert property (p_inc_to_work) else $error("increment to W wrong");

    property p_inc_skip;
        @(posedge sys_clk) disable iff (!rst_b)
        (op == BCI_OP_INC_SKIP && inc_val == 8'h00) |=> (op == BCI_OP_IDLE);
    endproperty
    a_inc_skip: assert property (p_inc_skip) else $error("zero increment did not skip");

    property p_or_imm;
        @(posedge sys_clk) disable iff (!rst_b)
        (op == BCI_OP_OR_IMM) |=> (work_reg == $past(or_imm_val)) && (zero_flag == (work_reg == 8'h00));
    endproperty
    a_or_imm: assert property (p_or_imm) else $error("OR immediate wrong");

    property p_or_file;
        @(posedge sys_clk) disable iff (!rst_b)
        (op == BCI_OP_OR_FILE) |=> (zero_flag == ($past(or_file_val) == 8'h00))
            && (work_reg == ($past(dest_file) ? $past(work_reg) : $past(or_file_val)));
    endproperty
    a_or_file: assert property (p_or_file) else $error("OR file wrong");

    property p_store;
        @(posedge sys_clk) disable iff (!rst_b)
        (op == BCI_OP_STORE) |=> $stable(zero_flag) && $stable(work_reg);
    endproperty
    a_store: assert property (p_store) else $error("store changed W or flag");

    property p_move;
        @(posedge sys_clk) disable iff (!rst_b)
        (op == BCI_OP_MOVE_FILE && !dest_file) |=> (work_reg == $past(fval));
    endproperty
    a_move: assert property (p_move) else $error("move to W wrong");

    property p_move_zero;
        @(posedge sys_clk) disable iff (!rst_b)
        (op == BCI_OP_MOVE_FILE) |=> (zero_flag == ($past(fval) == 8'h00));
    endproperty
    a_move_zero: assert property (p_move_zero) else $error("move zero flag wrong");

    property p_load_imm;
        @(posedge sys_clk) disable iff (!rst_b)
        (op == BCI_OP_LOAD_IMM) |=> (work_reg == $past(lit)) && $stable(zero_flag);
    endproperty
    a_load_imm: assert property (p_load_imm) else $error("load immediate wrong");

    property p_option;
        @(posedge sys_clk) disable iff (!rst_b)
        (op == BCI_OP_OPTION) |=> (option_reg == $past(work_reg)) && $stable(zero_flag);
    endproperty
    a_option: assert property (p_option) else $error("option load wrong");

    property p_return;
        @(posedge sys_clk) disable iff (!rst_b)
        (op == BCI_OP_RETURN_IMM) |=> (pm_addr == $past(return_stack_top)) && (op == BCI_OP_IDLE)
            && (work_reg == $past(lit)) ##1 (pm_addr == $past(pm_addr) + BCI_PC_STEP);
    endproperty
    a_return: assert property (p_return) else $error("return sequence wrong");

    property p_idle;
        @(posedge sys_clk) disable iff (!rst_b)
        (op == BCI_OP_IDLE) |=> $stable(work_reg) && $stable(zero_flag) && $stable(option_reg)
            && (pm_addr == $past(pm_addr) + BCI_PC_STEP);
    endproperty
    a_idle: assert property (p_idle) else $error("idle changed state");

endmodule : bci_core

`default_nettype wire

// ### testbench/bci_prog_model.sv
// Purpose: Program memory and return stack facing the core
// Assumes: The bench fills mem before reset is released
// Notes:   A fresh return address is drawn after each pop, so returns wander
`timescale 1ns/1ps
`default_nettype none
module bci_prog_model (
    // Clock
    input  wire logic        sys_clk,
    // Fetch
    input  wire logic [8:0]  pm_addr,
    output logic [11:0]      pm_data,
    // Return stack
    input  wire logic        return_pop,
    output logic [8:0]       return_stack_top
);
    logic [11:0] mem [512];
    logic [8:0]  stack_top = 9'h040;

    assign return_stack_top = stack_top;

    // Answer in the same cycle, no wait state exists on this path
    assign pm_data = mem[pm_addr];

    always @(posedge sys_clk) begin
        if (return_pop === 1'b1) begin
            stack_top <= 9'($urandom);
        end
    end
endmodule : bci_prog_model
`default_nettype wire

// ### testbench/tb_baseline_cpu_instr_subset.sv
// Purpose: Self-checking bench running random subset programs against a reference
// Assumes: Files 0..31 are written by the program prologue before use
// Notes:   Unwritten file contents read back as unknown and are not compared
`timescale 1ns/1ps
`default_nettype none
module tb_baseline_cpu_instr_subset;
    import bci_pkg::*;
    typedef struct packed {
        logic [8:0] pc;
        logic [7:0] w;
        logic       z;
        logic [7:0] opt;
        logic [7:0] peek;
        logic       pop;
        logic       unk;
    } bci_exp_type;

    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [4:0]  file_peek_addr = 5'h00;
    logic [8:0]  pm_addr, return_stack_top, pc;
    logic [11:0] pm_data, ex;
    logic        return_pop, zero_flag, unknown_op, z;
    logic [7:0]  work_reg, option_reg, file_peek_data, w, opt, pk;
    logic [7:0]  fm [32];
    bci_exp_type exp_q [$];
    int          n_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;

    always #25 sys_clk = ~sys_clk;

    bci_core i_bci_core (.sys_clk(sys_clk), .rst_b(rst_b), .pm_addr(pm_addr), .pm_data(pm_data),
        .return_stack_top(return_stack_top), .return_pop(return_pop), .work_reg(work_reg),
        .option_reg(option_reg), .zero_flag(zero_flag), .unknown_op(unknown_op),
        .file_peek_addr(file_peek_addr), .file_peek_data(file_peek_data));
    bci_prog_model i_bci_prog_model (.sys_clk(sys_clk), .pm_addr(pm_addr), .pm_data(pm_data),
        .return_pop(return_pop), .return_stack_top(return_stack_top));

    // --------------------------------------------------------------
    // Reference model
    // --------------------------------------------------------------
    function automatic bci_op_type decode(input logic [11:0] i);
        if (i == BCI_OPC_IDLE) return BCI_OP_IDLE;
        if (i == BCI_OPC_OPTION) return BCI_OP_OPTION;
        if ((i & BCI_MASK_STORE) == BCI_OPC_STORE) return BCI_OP_STORE;
        if ((i & BCI_MASK_FILE_D) == BCI_OPC_OR_FILE) return BCI_OP_OR_FILE;
        if ((i & BCI_MASK_FILE_D) == BCI_OPC_MOVE_FILE) return BCI_OP_MOVE_FILE;
        if ((i & BCI_MASK_FILE_D) == BCI_OPC_INC_SKIP) return BCI_OP_INC_SKIP;
        if ((i & BCI_MASK_LITERAL) == BCI_OPC_RETURN_IMM) return BCI_OP_RETURN_IMM;
        if ((i & BCI_MASK_LITERAL) == BCI_OPC_LOAD_IMM) return BCI_OP_LOAD_IMM;
        if ((i & BCI_MASK_LITERAL) == BCI_OPC_OR_IMM) return BCI_OP_OR_IMM;
        return BCI_OP_UNKNOWN;
    endfunction : decode

    task automatic step();
        logic [7:0] r;
        logic [4:0] f;
        bci_op_type op;
        f = ex[4:0];
        op = decode(ex);
        r = 8'h00;
        case (op)
            BCI_OP_OPTION:     opt = w;
            BCI_OP_STORE:      fm[f] = w;
            BCI_OP_OR_FILE:    r = w | fm[f];
            BCI_OP_MOVE_FILE:  r = fm[f];
            BCI_OP_INC_SKIP:   r = fm[f] + BCI_INC_STEP;
            BCI_OP_RETURN_IMM: w = ex[7:0];
            BCI_OP_LOAD_IMM:   w = ex[7:0];
            BCI_OP_OR_IMM:     w = w | ex[7:0];
            default:           r = 8'h00;
        endcase
        if (op inside {BCI_OP_OR_FILE, BCI_OP_MOVE_FILE, BCI_OP_INC_SKIP}) begin
            if (ex[BCI_DEST_BIT]) fm[f] = r;
            else w = r;
        end
        if (op inside {BCI_OP_OR_FILE, BCI_OP_MOVE_FILE}) z = (r == 8'h00);
        if (op == BCI_OP_OR_IMM) z = (w == 8'h00);
        // Skipped or returned-over word is dropped, an idle fills its slot
        if (op == BCI_OP_RETURN_IMM || (op == BCI_OP_INC_SKIP && r == 8'h00)) ex = BCI_OPC_IDLE;
        else ex = i_bci_prog_model.mem[pc];
        pc = (op == BCI_OP_RETURN_IMM) ? return_stack_top : pc + BCI_PC_STEP;
    endtask : step

    function automatic logic [7:0] lit();
        int s;
        s = $urandom_range(2);
        return (s == 0) ? 8'h00 : (s == 1) ? 8'hff : 8'($urandom);
    endfunction : lit

    // --------------------------------------------------------------
    // Checking
    // --------------------------------------------------------------
    task automatic cmp_val(input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : cmp_val

    task automatic cmp_flag(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected flag at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : cmp_flag

    always @(negedge sys_clk) begin
        bci_exp_type e;
        #5;
        if (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            cmp_val(pm_addr, e.pc);
            cmp_val({1'b0, work_reg}, {1'b0, e.w});
            cmp_val({1'b0, option_reg}, {1'b0, e.opt});
            cmp_flag(zero_flag, e.z);
            cmp_flag(return_pop, e.pop);
            cmp_flag(unknown_op, e.unk);
            if (!$isunknown(e.peek)) begin
                cmp_val({1'b0, file_peek_data}, {1'b0, e.peek});
            end
        end
    end

    task automatic run_phase(input int n);
        pc = BCI_PC_RESET;
        ex = BCI_OPC_IDLE;
        w = BCI_W_RESET;
        opt = BCI_OPTION_RESET;
        z = BCI_ZERO_RESET;
        pk = 8'h00;
        rst_b = 1'b1;
        repeat (n) begin
            exp_q.push_back('{pc, w, z, opt, pk, decode(ex) == BCI_OP_RETURN_IMM, decode(ex) == BCI_OP_UNKNOWN});
            file_peek_addr = 5'($urandom);
            pk = fm[file_peek_addr];
            step();
            @(negedge sys_clk);
        end
        rst_b = 1'b0;
        repeat (2) @(negedge sys_clk);
        $display("phase of %0d cycles done", n);
    endtask : run_phase

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // Cut a hang short well above the expected run of about 3000 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    initial begin
        logic [11:0] fd;
        void'($urandom(32'h83340564));
        // Prologue gives every file a known value, biased to 00 and ff
        for (int a = 0; a < 32; a++) begin
            i_bci_prog_model.mem[2 * a] = BCI_OPC_LOAD_IMM | {4'h0, lit()};
            i_bci_prog_model.mem[2 * a + 1] = BCI_OPC_STORE | 12'(a);
        end
        for (int a = 64; a < 512; a++) begin
            fd = {6'h00, 6'($urandom)};
            case ($urandom_range(9))
                0:       i_bci_prog_model.mem[a] = BCI_OPC_IDLE;
                1:       i_bci_prog_model.mem[a] = BCI_OPC_OPTION;
                2:       i_bci_prog_model.mem[a] = BCI_OPC_STORE | (fd & 12'h01f);
                3:       i_bci_prog_model.mem[a] = BCI_OPC_OR_FILE | fd;
                4:       i_bci_prog_model.mem[a] = BCI_OPC_MOVE_FILE | fd;
                5:       i_bci_prog_model.mem[a] = BCI_OPC_INC_SKIP | fd;
                6:       i_bci_prog_model.mem[a] = BCI_OPC_RETURN_IMM | {4'h0, lit()};
                7:       i_bci_prog_model.mem[a] = BCI_OPC_LOAD_IMM | {4'h0, lit()};
                8:       i_bci_prog_model.mem[a] = BCI_OPC_OR_IMM | {4'h0, lit()};
                default: i_bci_prog_model.mem[a] = 12'($urandom);
            endcase
        end
        repeat (10) @(negedge sys_clk);
        run_phase(1500);
        run_phase(1500);
        #20;
        tally_and_finish();
    end
endmodule : tb_baseline_cpu_instr_subset
`default_nettype wire
